// ### hw/cpuab_pkg.sv
// constants, types and encodings for the alu and branch execution block
// ****************************************************************
// Contract
// RULE_01 - add with carry sums working register, file operand and carry, and sets all five flags.
// RULE_02 - byte file results go to the working register when d is 0, to the file when d is 1.
// RULE_03 - with a at 0 the access bank is used, with a at 1 the bank select register picks the bank.
// RULE_04 - with a at 0, extended set on and f at most 5Fh, indexed literal offset addressing is used.
// RULE_05 - and literal ands the working register with the 8-bit literal into the working register.
// RULE_06 - and file ands the working register with the file operand into the chosen destination.
// RULE_07 - both and operations update only n and z.
// RULE_08 - branch on carry set branches only when c is 1, else falls through.
// RULE_09 - branch on negative set branches only when n is 1, else falls through.
// RULE_10 - branch on carry clear branches only when c is 0, else falls through.
// RULE_11 - the branch offset is a signed byte, doubled and added to the incremented counter.
// RULE_12 - a taken branch loads pc plus 2 plus 2n in two cycles, the second a no-op; else one cycle.
// RULE_13 - conditional branches change no status flag.
// RULE_14 - bit clear in file clears bit b of the file operand by read-modify-write, no flag change.
// RULE_15 - single-word alu operations take one cycle: decode, read, process, write.
// ****************************************************************
package cpuab_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSTR = 8'h04;
    localparam logic [7:0] OFF_FLAGS = 8'h08;
    localparam logic [7:0] OFF_WREG = 8'h0C;
    localparam logic [7:0] OFF_PC = 8'h10;
    localparam logic [7:0] OFF_BANK = 8'h14;
    localparam logic [7:0] OFF_INDEX = 8'h18;
    localparam logic [7:0] OFF_DADDR = 8'h1C;
    localparam logic [7:0] OFF_DDATA = 8'h20;
    localparam logic [7:0] OFF_STAT = 8'h24;
    localparam int CTRL_EXT_BIT = 0;
    localparam int STAT_BUSY_BIT = 1 - 1;
    localparam int STAT_BAD_BIT = 1;
    localparam int FLAG_C = 0;
    localparam int FLAG_DIGIT = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OVF = 3;
    localparam int FLAG_N = 4;
    // ************************************************************
    // widths and reset values
    // ************************************************************
    localparam int PC_W = 21;
    localparam int AW = 12;
    localparam logic [7:0] RST_WREG = 8'h00;
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [PC_W-1:0] RST_PC = 21'h000000;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [AW-1:0] RST_INDEX = 12'h000;
    localparam logic [15:0] RST_INSTR = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    // ************************************************************
    // encodings and addressing
    // ************************************************************
    localparam logic [5:0] OPC_ADDC = 6'h08;
    localparam logic [5:0] OPC_ANDF = 6'h05;
    localparam logic [7:0] OPC_ANDL = 8'h0B;
    localparam logic [7:0] OPC_BR_CSET = 8'hE2;
    localparam logic [7:0] OPC_BR_NSET = 8'hE6;
    localparam logic [7:0] OPC_BR_CCLR = 8'hE3;
    localparam logic [3:0] OPC_BIT_CLR = 4'h9;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [3:0] SFR_BANK = 4'hF;
    typedef enum logic [3:0] {
        ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_N1, ST_N2, ST_N3, ST_N4
    } cpuab_state_type;
endpackage : cpuab_pkg

// ### hw/cpuab_add8.sv
// eight-bit adder with carry in and status outputs
module cpuab_add8 (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] sum,
    output logic cout,
    output logic dcout,
    output logic ovf
);
    logic [8:0] full;
    logic [4:0] low;
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        sum = full[7:0];
        cout = full[8];
        dcout = low[4];
        ovf = (a[7] == b[7]) && (full[7] != a[7]);
    end
endmodule : cpuab_add8

// ### hw/cpuab_branch.sv
// condition test and target for relative conditional branches
module cpuab_branch
    import cpuab_pkg::*;
(
    input wire logic [7:0] opc,
    input wire logic flag_c,
    input wire logic flag_n,
    input wire logic [cpuab_pkg::PC_W-1:0] pc,
    input wire logic [7:0] offs,
    output logic is_branch,
    output logic take,
    output logic [cpuab_pkg::PC_W-1:0] target
);
    import cpuab_pkg::*;
    always_comb begin
        is_branch = 1'b1;
        take = 1'b0;
        case (opc)
            OPC_BR_CSET: take = flag_c; // RULE_08
            OPC_BR_NSET: take = flag_n; // RULE_09
            OPC_BR_CCLR: take = !flag_c; // RULE_10
            default: is_branch = 1'b0;
        endcase
        target = pc + {{12{offs[7]}}, offs, 1'b0}; // RULE_11
    end
endmodule : cpuab_branch

// ### hw/cpuab_core.sv
// apb-controlled execution core for add, and, bit clear and branches
//
// Design decisions made here: the register addresses and register access over APB.
module cpuab_core
    import cpuab_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import cpuab_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    cpuab_state_type state;
    logic [15:0] instr;
    logic [7:0] wreg;
    logic [4:0] flags;
    logic [PC_W-1:0] pc;
    logic [3:0] bank;
    logic [AW-1:0] index;
    logic [AW-1:0] daddr;
    logic ext_en;
    logic bad_op;
    logic [7:0] opnd;
    logic [AW-1:0] addr_q;
    logic [7:0] res;
    logic [4:0] res_flags;
    logic [7:0] dmem [0:4095];

    logic busy;
    logic is_addc;
    logic is_andf;
    logic is_andl;
    logic is_bitclr;
    logic is_br;
    logic br_take;
    logic [PC_W-1:0] br_target;
    logic dest_f;
    logic [7:0] fld;
    logic [AW-1:0] eff_addr;
    logic [7:0] add_sum;
    logic add_c;
    logic add_digit;
    logic add_ovf;
    logic [7:0] next_res;
    logic [4:0] next_flags;
    logic wr_ok;
    logic start;
    logic next_err;
    logic [31:0] rdata;

    // ************************************************************
    // decode
    // ************************************************************
    assign busy = (state != ST_IDLE);
    assign fld = instr[7:0];
    assign is_addc = (instr[15:10] == OPC_ADDC);
    assign is_andf = (instr[15:10] == OPC_ANDF);
    assign is_andl = (instr[15:8] == OPC_ANDL);
    assign is_bitclr = (instr[15:12] == OPC_BIT_CLR);
    assign dest_f = instr[9];

    always_comb begin
        if (instr[8]) begin
            eff_addr = {bank, fld}; // RULE_03
        end else if (ext_en && fld <= IDX_LIMIT) begin
            eff_addr = index + {4'h0, fld}; // RULE_04
        end else if (fld < ACC_SPLIT) begin
            eff_addr = {4'h0, fld}; // RULE_03
        end else begin
            eff_addr = {SFR_BANK, fld};
        end
    end

    cpuab_add8 u_add (
        .a(wreg),
        .b(opnd),
        .cin(flags[FLAG_C]),
        .sum(add_sum),
        .cout(add_c),
        .dcout(add_digit),
        .ovf(add_ovf)
    );

    cpuab_branch u_branch (
        .opc(instr[15:8]),
        .flag_c(flags[FLAG_C]),
        .flag_n(flags[FLAG_N]),
        .pc(pc),
        .offs(fld),
        .is_branch(is_br),
        .take(br_take),
        .target(br_target)
    );

    // ************************************************************
    // process data
    // ************************************************************
    always_comb begin
        next_res = opnd;
        next_flags = flags;
        if (is_addc) begin
            next_res = add_sum; // RULE_01
            next_flags[FLAG_C] = add_c;
            next_flags[FLAG_DIGIT] = add_digit;
            next_flags[FLAG_OVF] = add_ovf;
        end else if (is_andf) begin
            next_res = wreg & opnd; // RULE_06
        end else if (is_andl) begin
            next_res = wreg & fld; // RULE_05
        end else if (is_bitclr) begin
            next_res = opnd & ~(8'h01 << instr[11:9]); // RULE_14
        end
        if (is_addc || is_andf || is_andl) begin
            next_flags[FLAG_N] = next_res[7]; // RULE_07
            next_flags[FLAG_Z] = (next_res == 8'h00);
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    assign start = wr_ok && (paddr == OFF_INSTR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: state <= start ? ST_Q1 : ST_IDLE;
                ST_Q1: state <= ST_Q2; // RULE_15
                ST_Q2: state <= ST_Q3;
                ST_Q3: state <= ST_Q4;
                ST_Q4: state <= (is_br && br_take) ? ST_N1 : ST_IDLE; // RULE_12
                ST_N1: state <= ST_N2;
                ST_N2: state <= ST_N3;
                ST_N3: state <= ST_N4;
                ST_N4: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd <= 8'h00;
            addr_q <= '0;
            res <= 8'h00;
            res_flags <= RST_FLAGS;
        end else if (state == ST_Q2) begin
            opnd <= dmem[eff_addr];
            addr_q <= eff_addr;
        end else if (state == ST_Q3) begin
            res <= next_res;
            res_flags <= next_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_op <= 1'b0;
        end else if (start) begin
            bad_op <= 1'b0;
        end else if (state == ST_Q1) begin
            bad_op <= !(is_addc || is_andf || is_andl || is_bitclr || is_br);
        end
    end

    // ************************************************************
    // architectural registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wreg <= RST_WREG;
        end else if (state == ST_Q4) begin
            if (((is_addc || is_andf) && !dest_f) || is_andl) begin
                wreg <= res; // RULE_02
            end
        end else if (wr_ok && paddr == OFF_WREG) begin
            wreg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= RST_FLAGS;
        end else if (state == ST_Q4) begin
            flags <= res_flags; // RULE_13
        end else if (wr_ok && paddr == OFF_FLAGS) begin
            flags <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= RST_PC;
        end else if (state == ST_Q1) begin
            pc <= pc + PC_STEP; // RULE_11
        end else if (state == ST_Q4 && is_br && br_take) begin
            pc <= br_target; // RULE_12
        end else if (wr_ok && paddr == OFF_PC) begin
            pc <= {pwdata[PC_W-1:1], 1'b0};
        end
    end

    always_ff @(posedge pclk) begin
        if (state == ST_Q4 && (((is_addc || is_andf) && dest_f) || is_bitclr)) begin
            dmem[addr_q] <= res; // RULE_02
        end else if (wr_ok && paddr == OFF_DDATA) begin
            dmem[daddr] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr <= RST_INSTR;
            bank <= RST_BANK;
            index <= RST_INDEX;
            daddr <= '0;
            ext_en <= 1'b0;
        end else if (wr_ok) begin
            if (paddr == OFF_INSTR) begin
                instr <= pwdata[15:0];
            end
            if (paddr == OFF_BANK) begin
                bank <= pwdata[3:0];
            end
            if (paddr == OFF_INDEX) begin
                index <= pwdata[AW-1:0];
            end
            if (paddr == OFF_DADDR) begin
                daddr <= pwdata[AW-1:0];
            end
            if (paddr == OFF_CTRL) begin
                ext_en <= pwdata[CTRL_EXT_BIT];
            end
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        rdata = 32'h00000000;
        next_err = 1'b0;
        unique case (paddr)
            OFF_CTRL: rdata[CTRL_EXT_BIT] = ext_en;
            OFF_INSTR: rdata[15:0] = instr;
            OFF_FLAGS: rdata[4:0] = flags;
            OFF_WREG: rdata[7:0] = wreg;
            OFF_PC: rdata[PC_W-1:0] = pc;
            OFF_BANK: rdata[3:0] = bank;
            OFF_INDEX: rdata[AW-1:0] = index;
            OFF_DADDR: rdata[AW-1:0] = daddr;
            OFF_DDATA: rdata[7:0] = dmem[daddr];
            OFF_STAT: rdata[1:0] = {bad_op, busy};
            default: next_err = 1'b1;
        endcase
        if (pwrite && (busy || paddr == OFF_STAT)) begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= next_err;
                prdata <= (pwrite || next_err) ? 32'h00000000 : rdata;
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_nop_cycle;
        state == ST_N1 ##1 state == ST_N2 ##1 state == ST_N3 ##1 state == ST_N4
            ##1 state == ST_IDLE;
    endsequence

    sequence s_alu_cycle;
        state == ST_Q1 ##1 state == ST_Q2 ##1 state == ST_Q3 ##1 state == ST_Q4;
    endsequence

    a_add_flags: assert property (state == ST_Q3 && is_addc |=> ##1 // RULE_01
        flags[FLAG_C] == $past(add_c, 2) && flags[FLAG_OVF] == $past(add_ovf, 2))
        else $error("add with carry flags wrong");

    a_dest_select: assert property (state == ST_Q4 && is_addc && !dest_f |=> // RULE_02
        wreg == $past(res) && dmem[$past(addr_q)] == $past(dmem[addr_q]))
        else $error("destination select wrong");

    a_bank_select: assert property (state == ST_Q2 && instr[8] |=> // RULE_03
        addr_q == {bank, fld})
        else $error("bank select address wrong");

    a_indexed_mode: assert property (state == ST_Q2 && !instr[8] && ext_en // RULE_04
        && fld <= 8'h5F |=> addr_q == $past(index) + {4'h0, $past(fld)})
        else $error("indexed offset address wrong");

    a_and_literal: assert property (state == ST_Q3 && is_andl |=> ##1 // RULE_05
        wreg == ($past(wreg, 2) & $past(fld, 2)))
        else $error("and literal result wrong");

    a_and_file: assert property (state == ST_Q4 && is_andf && dest_f |=> // RULE_06
        dmem[$past(addr_q)] == ($past(wreg) & $past(opnd)) && $stable(wreg))
        else $error("and file result wrong");

    a_and_flags: assert property (state == ST_Q4 && (is_andf || is_andl) |=> // RULE_07
        flags[FLAG_C] == $past(flags[FLAG_C]) && flags[FLAG_DIGIT] == $past(flags[FLAG_DIGIT])
        && flags[FLAG_OVF] == $past(flags[FLAG_OVF]))
        else $error("and changed other flags");

    a_carry_branch: assert property (state == ST_Q4 && instr[15:8] == 8'hE2 |=> // RULE_08
        pc == ($past(flags[FLAG_C]) ? $past(br_target) : $past(pc)))
        else $error("carry set branch wrong");

    a_neg_branch: assert property (state == ST_Q4 && instr[15:8] == 8'hE6 |=> // RULE_09
        pc == ($past(flags[FLAG_N]) ? $past(br_target) : $past(pc)))
        else $error("negative branch wrong");

    a_nocarry_branch: assert property (state == ST_Q4 && instr[15:8] == 8'hE3 |=> // RULE_10
        pc == ($past(flags[FLAG_C]) ? $past(pc) : $past(br_target)))
        else $error("carry clear branch wrong");

    a_branch_target: assert property (state == ST_Q1 && is_br |=> ##2 // RULE_11
        br_target == $past(pc, 3) + 21'h000002 + {{12{fld[7]}}, fld, 1'b0})
        else $error("branch target wrong");

    a_taken_timing: assert property (state == ST_Q4 && is_br && br_take |=> // RULE_12
        s_nop_cycle)
        else $error("taken branch timing wrong");

    a_branch_flags: assert property (state == ST_Q1 && is_br |=> // RULE_13
        ##3 flags == $past(flags, 4))
        else $error("branch changed flags");

    a_bit_clear: assert property (state == ST_Q4 && is_bitclr |=> // RULE_14
        dmem[$past(addr_q)] == ($past(opnd) & ~(8'h01 << $past(instr[11:9])))
        && $stable(flags))
        else $error("bit clear wrong");

    a_one_cycle: assert property (start |=> s_alu_cycle ##1 // RULE_15
        (state == ST_IDLE || state == ST_N1))
        else $error("instruction cycle length wrong");
endmodule : cpuab_core

// ### test/cpuab_apb_master.sv
// apb master model driving the core's register bus
module cpuab_apb_master (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ****************************************************************
    // one transfer: setup, access until pready, release
    // ****************************************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask : xfer
endmodule : cpuab_apb_master

// ### test/cpuab_core_tb.sv
// self-checking bench for the alu and branch execution core
module cpuab_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cpuab_pkg::*;
    typedef struct {
        logic [15:0] instr;
        logic [7:0] w;
        logic [4:0] fl;
        logic [11:0] da;
        logic [7:0] m;
        logic [7:0] ew;
        logic [4:0] efl;
        logic [7:0] em;
        logic [20:0] epc;
        logic lng;
    } cpuab_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int fail_count = 0;
    int n_compared = 0;
    cpuab_row_type r;
    cpuab_row_type rows [13] = '{
        '{16'h2110, 8'h4D, 5'h01, 12'h210, 8'h02, 8'h50, 5'h02, 8'h02, 21'h102, 1'b0},
        '{16'h2310, 8'h80, 5'h00, 12'h210, 8'h80, 8'h80, 5'h0D, 8'h00, 21'h102, 1'b0},
        '{16'h0B5F, 8'hA3, 5'h1F, 12'h210, 8'h55, 8'h03, 5'h0B, 8'h55, 21'h102, 1'b0},
        '{16'h1420, 8'h17, 5'h04, 12'h020, 8'hC2, 8'h02, 5'h00, 8'hC2, 21'h102, 1'b0},
        '{16'h1680, 8'h0F, 5'h13, 12'hF80, 8'hF0, 8'h0F, 5'h07, 8'h00, 21'h102, 1'b0},
        '{16'h1510, 8'hF0, 5'h00, 12'h210, 8'h80, 8'h80, 5'h10, 8'h80, 21'h102, 1'b0},
        '{16'h9F10, 8'h11, 5'h1F, 12'h210, 8'hC7, 8'h11, 5'h1F, 8'h47, 21'h102, 1'b0},
        '{16'hE205, 8'h11, 5'h01, 12'h210, 8'h33, 8'h11, 5'h01, 8'h33, 21'h10C, 1'b1},
        '{16'hE205, 8'h11, 5'h1E, 12'h210, 8'h33, 8'h11, 5'h1E, 8'h33, 21'h102, 1'b0},
        '{16'hE680, 8'h11, 5'h10, 12'h210, 8'h33, 8'h11, 5'h10, 8'h33, 21'h002, 1'b1},
        '{16'hE680, 8'h11, 5'h0F, 12'h210, 8'h33, 8'h11, 5'h0F, 8'h33, 21'h102, 1'b0},
        '{16'hE37F, 8'h11, 5'h00, 12'h210, 8'h33, 8'h11, 5'h00, 8'h33, 21'h200, 1'b1},
        '{16'hE37F, 8'h11, 5'h01, 12'h210, 8'h33, 8'h11, 5'h01, 8'h33, 21'h102, 1'b0}
    };
    logic [7:0] rst_addr [9] = '{OFF_CTRL, OFF_INSTR, OFF_FLAGS, OFF_WREG, OFF_PC, OFF_BANK,
                                 OFF_INDEX, OFF_DADDR, OFF_STAT};
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    cpuab_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    cpuab_apb_master u_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ****************************************************************
    // compare, bus access, instruction run, verdict
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic e, input string what);
        logic [31:0] q;
        logic err;
        u_master.xfer(w, a, d, q, err);
        chk({what, " err"}, {31'h0, e}, {31'h0, err});
        if (!w && !e) begin
            chk(what, d, q);
        end
    endtask : bus
    task automatic run(input logic [15:0] ins, input logic lng, input logic bad);
        bus(1'b1, OFF_INSTR, {16'h0, ins}, 1'b0, "instr");
        bus(1'b0, OFF_STAT, {30'h0, bad, 1'b1}, 1'b0, "busy early");
        bus(1'b0, OFF_STAT, {30'h0, bad, lng}, 1'b0, "busy late");
        bus(1'b0, OFF_STAT, {30'h0, bad, 1'b0}, 1'b0, "idle");
    endtask : run
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b1, OFF_BANK, 32'h2, 1'b0, "bank");
        for (int i = 0; i < 13; i++) begin
            r = rows[i];
            bus(1'b1, OFF_WREG, {24'h0, r.w}, 1'b0, "wreg set");
            bus(1'b1, OFF_FLAGS, {27'h0, r.fl}, 1'b0, "flags set");
            bus(1'b1, OFF_PC, 32'h100, 1'b0, "pc set");
            bus(1'b1, OFF_DADDR, {20'h0, r.da}, 1'b0, "daddr");
            bus(1'b1, OFF_DDATA, {24'h0, r.m}, 1'b0, "ddata set");
            run(r.instr, r.lng, 1'b0);
            bus(1'b0, OFF_WREG, {24'h0, r.ew}, 1'b0, "wreg");
            bus(1'b0, OFF_FLAGS, {27'h0, r.efl}, 1'b0, "flags");
            bus(1'b0, OFF_DDATA, {24'h0, r.em}, 1'b0, "file");
            bus(1'b0, OFF_PC, {11'h0, r.epc}, 1'b0, "pc");
        end
        // indexed offset at the top of the low window
        bus(1'b1, OFF_CTRL, 32'h1, 1'b0, "ext on");
        bus(1'b1, OFF_INDEX, 32'h300, 1'b0, "index");
        bus(1'b1, OFF_WREG, 32'h3C, 1'b0, "wreg set");
        bus(1'b1, OFF_DADDR, 32'h35F, 1'b0, "daddr");
        bus(1'b1, OFF_DDATA, 32'hFF, 1'b0, "ddata set");
        bus(1'b1, OFF_DADDR, 32'h05F, 1'b0, "daddr");
        bus(1'b1, OFF_DDATA, 32'hFF, 1'b0, "ddata set");
        run(16'h165F, 1'b0, 1'b0);
        bus(1'b0, OFF_DDATA, 32'hFF, 1'b0, "access untouched");
        bus(1'b1, OFF_DADDR, 32'h35F, 1'b0, "daddr");
        bus(1'b0, OFF_DDATA, 32'h3C, 1'b0, "indexed file");
        // refused accesses: writes while busy and to status, unmapped write and read
        bus(1'b1, OFF_FLAGS, 32'h1, 1'b0, "flags set");
        bus(1'b1, OFF_INSTR, 32'hE205, 1'b0, "instr");
        bus(1'b1, OFF_WREG, 32'hAA, 1'b1, "write busy");
        repeat (10) @(posedge pclk);
        bus(1'b0, OFF_WREG, 32'h3C, 1'b0, "wreg kept");
        bus(1'b1, OFF_STAT, 32'h3, 1'b1, "stat write");
        bus(1'b1, 8'h28, 32'h1, 1'b1, "unmapped write");
        bus(1'b0, 8'h28, 32'h0, 1'b1, "unmapped read");
        // unsupported opcode still advances the counter
        bus(1'b1, OFF_PC, 32'h100, 1'b0, "pc set");
        run(16'hFFFF, 1'b0, 1'b1);
        bus(1'b0, OFF_PC, 32'h102, 1'b0, "pc bad op");
        // second reset with the core idle after the last run
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, rst_addr[i], 32'h0, 1'b0, "reset value");
        end
        tally_and_finish();
    end
endmodule : cpuab_core_tb
